// *** include/pxi_pkg.sv ***
package pxi_pkg;
   // Core clock and reference detection figures
   localparam int CLK_HZ           = 40000000;
   localparam int REF_HZ           = 10000000;
   // Reference is seen present after this many of its rising edges in a row
   localparam int REF_DET_EDGES    = 16;
   // Longest allowed gap between reference edges while detecting, in ns
   localparam int REF_GAP_NS       = 200;
   localparam int REF_GAP_CYC      = (REF_GAP_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int INT_W            = 8;
   localparam logic [7:0] INT_RST  = 8'hFF;   // Pulled-high pins read as all ones
   localparam int CNT_W            = 8;

   // Start request toward the sequencer: address of first instruction
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
   } pxi_start_t;

   // Interrupt request toward the sequencer
   typedef struct packed {
      logic       valid;
      logic [7:0] num;
   } pxi_irq_t;

   typedef enum logic [1:0] {
      PXI_REF_INT  = 2'b00,
      PXI_REF_SEEK = 2'b01,
      PXI_REF_EXT  = 2'b10
   } pxi_ref_t;
endpackage

// *** core/pxi_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous pins
module pxi_sync
   import pxi_pkg::*;
#(
   parameter int          W     = 1,
   parameter logic [W-1:0] RSTV = '0
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= RSTV;
         q        <= RSTV;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// *** core/pxi_top.sv ***
// Functional notes
// - Low start pin requests program run
// - Start is level sensitive, repeats while low
// - Start fetches from interrupt-selected address
// - Hardware start equals software start command
// - Low reset pin clears program counter
// - Eight active-high bits form interrupt number
// - Interrupt pins ignored unless hardware enabled
// - Hardware number equals software interrupt command
// - Undriven interrupt pins read as ones
// - Switch to external reference when detected
// - Keep external reference until power reset
module pxi_top
   import pxi_pkg::*;
(
   input  wire logic         I_CLK,
   input  wire logic         I_ARST_N,
   input  wire logic         I_START_N,
   input  wire logic         I_PC_RESET_N,
   input  wire logic [7:0]   I_INT_NUM,
   input  wire logic         I_REF_CLK,
   input  wire logic         I_HW_INT_EN,
   input  wire logic         I_SW_START,
   input  wire logic         I_SW_RESET,
   input  wire logic         I_SW_INT_VALID,
   input  wire logic [7:0]   I_SW_INT_NUM,
   output logic              O_START,
   output logic [7:0]        O_START_ADDR,
   output logic              O_PC_CLEAR,
   output logic              O_INT_VALID,
   output logic [7:0]        O_INT_NUM,
   output logic              O_REF_SEL_EXT,
   output logic              O_REF_DETECTING
);
   // Synchronised copies of the pins
   logic             start_n_s;
   logic             rst_n_s;
   logic [INT_W-1:0] int_s;
   logic             ref_s;
   logic             ref_d_reg;
   logic             ref_rise;
   // Request registers toward the sequencer
   pxi_start_t       start_reg, start_next;
   pxi_irq_t         irq_reg, irq_next;
   logic             clr_reg, clr_next;
   // Reference detector state, counters and registered flags
   pxi_ref_t         ref_state_reg, ref_state_next;
   logic             sel_ext_reg, sel_ext_next;
   logic             det_reg, det_next;
   logic [CNT_W-1:0] edge_cnt_reg, edge_cnt_next;
   logic [CNT_W-1:0] gap_cnt_reg, gap_cnt_next;

   // Pins are asynchronous to the core; pull-high pins reset to one
   pxi_sync #(.W(1), .RSTV(1'b1)) u_sync_start (
      .clk    (I_CLK),
      .arst_n (I_ARST_N),
      .d      (I_START_N),
      .q      (start_n_s)
   );
   // Reset pin idles high, so a cold start never clears the counter
   pxi_sync #(.W(1), .RSTV(1'b1)) u_sync_rst (
      .clk    (I_CLK),
      .arst_n (I_ARST_N),
      .d      (I_PC_RESET_N),
      .q      (rst_n_s)
   );
   // Pull-ups make an unplugged connector read as the top number
   pxi_sync #(.W(INT_W), .RSTV(INT_RST)) u_sync_int (
      .clk    (I_CLK),
      .arst_n (I_ARST_N),
      .d      (I_INT_NUM),
      .q      (int_s)
   );
   // Reference is sampled as data; the core clock gives four samples a period
   pxi_sync #(.W(1), .RSTV(1'b0)) u_sync_ref (
      .clk    (I_CLK),
      .arst_n (I_ARST_N),
      .d      (I_REF_CLK),
      .q      (ref_s)
   );

   // Start request: pin level or software command, same outcome.
   // Pin to output is three edges: two sync stages and one register.
   always_comb begin
      start_next.valid = !start_n_s || I_SW_START;
      // Address follows the interrupt pins only when hardware control is on
      start_next.addr  = I_HW_INT_EN ? int_s : I_SW_INT_NUM;
   end

   // Interrupt number; bit 0 is the least significant pin
   always_comb begin
      irq_next = '0;
      if (I_HW_INT_EN) begin
         irq_next.valid = 1'b1;
         irq_next.num   = int_s;
      end else if (I_SW_INT_VALID) begin
         irq_next.valid = 1'b1;
         irq_next.num   = I_SW_INT_NUM;
      end
   end

   // Start register re-asserts every cycle the pin stays low
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         start_reg <= '0;
      end else begin
         start_reg <= start_next;
      end
   end

   // Interrupt register, rewritten each cycle from its request
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // Program counter clear, pin or software command; both are levels
   always_comb begin
      clr_next = !rst_n_s || I_SW_RESET;
   end

   // Clear stands while either source stays asserted
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         clr_reg <= 1'b0;
      end else begin
         clr_reg <= clr_next;
      end
   end

   // Reference edge detector reads the synchronised copy only
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ref_d_reg <= 1'b0;
      end else begin
         ref_d_reg <= ref_s;
      end
   end
   assign ref_rise = ref_s && !ref_d_reg;

   // Reference detection: a run of edges with short gaps selects it.
   // EXT has no exit, so only the power-on reset returns to internal.
   always_comb begin
      ref_state_next = ref_state_reg;
      edge_cnt_next  = edge_cnt_reg;
      gap_cnt_next   = gap_cnt_reg;
      case (ref_state_reg)
         PXI_REF_INT: begin
            if (ref_rise) begin
               ref_state_next = PXI_REF_SEEK;
               edge_cnt_next  = CNT_W'(1);
               gap_cnt_next   = '0;
            end
         end
         PXI_REF_SEEK: begin
            if (ref_rise) begin
               // Each edge restarts the gap timer
               gap_cnt_next  = '0;
               edge_cnt_next = edge_cnt_reg + CNT_W'(1);
               if (edge_cnt_reg == CNT_W'(REF_DET_EDGES - 1)) begin
                  ref_state_next = PXI_REF_EXT;
               end
            end else if (gap_cnt_reg == CNT_W'(REF_GAP_CYC)) begin
               ref_state_next = PXI_REF_INT;     // Glitch or stopped, not a reference
               edge_cnt_next  = '0;
               gap_cnt_next   = '0;
            end else begin
               gap_cnt_next = gap_cnt_reg + CNT_W'(1);
            end
         end
         PXI_REF_EXT: begin
            ref_state_next = PXI_REF_EXT;
         end
         default: begin
            ref_state_next = PXI_REF_INT;
         end
      endcase
   end

   // Detector registers; only the power reset leaves EXT
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ref_state_reg <= PXI_REF_INT;
         edge_cnt_reg  <= '0;
         gap_cnt_reg   <= '0;
      end else begin
         ref_state_reg <= ref_state_next;
         edge_cnt_reg  <= edge_cnt_next;
         gap_cnt_reg   <= gap_cnt_next;
      end
   end

   // Flags follow the next state so they line up with the state register
   always_comb begin
      sel_ext_next = (ref_state_next == PXI_REF_EXT);
      det_next     = (ref_state_next == PXI_REF_SEEK);
   end

   // Flag registers keep the outputs free of decode logic
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         sel_ext_reg <= 1'b0;
         det_reg     <= 1'b0;
      end else begin
         sel_ext_reg <= sel_ext_next;
         det_reg     <= det_next;
      end
   end

   // Outputs come straight from their registers
   assign O_START         = start_reg.valid;
   assign O_START_ADDR    = start_reg.addr;
   assign O_PC_CLEAR      = clr_reg;
   assign O_INT_VALID     = irq_reg.valid;
   assign O_INT_NUM       = irq_reg.num;
   assign O_REF_SEL_EXT   = sel_ext_reg;
   assign O_REF_DETECTING = det_reg;
endmodule

// *** verif/pxi_chk.sv ***
module pxi_chk
   import pxi_pkg::*;
(
   input wire logic       I_CLK,
   input wire logic       I_ARST_N,
   input wire logic       I_START_N,
   input wire logic       I_PC_RESET_N,
   input wire logic [7:0] I_INT_NUM,
   input wire logic       I_HW_INT_EN,
   input wire logic       I_SW_START,
   input wire logic       I_SW_INT_VALID,
   input wire logic [7:0] I_SW_INT_NUM,
   input wire logic       O_START,
   input wire logic [7:0] O_START_ADDR,
   input wire logic       O_PC_CLEAR,
   input wire logic       O_INT_VALID,
   input wire logic [7:0] O_INT_NUM,
   input wire logic       O_REF_SEL_EXT
);
   timeunit 1ns;
   timeprecision 100ps;
   // One domain; a pin first sampled at one edge shows three edges later
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   property p_pin_start; !I_START_N |-> ##3 O_START; endproperty
   a_pin_start: assert property (p_pin_start) else $error("start pin ignored");
   property p_sw_start; I_SW_START |=> O_START; endproperty
   a_sw_start: assert property (p_sw_start) else $error("sw start ignored");
   property p_pin_clr; !I_PC_RESET_N |-> ##3 O_PC_CLEAR; endproperty
   a_pin_clr: assert property (p_pin_clr) else $error("pc clear missing");
   property p_addr;
      O_START && $past(I_HW_INT_EN) && !$past(I_SW_START) |-> O_START_ADDR == $past(I_INT_NUM, 3);
   endproperty
   a_addr: assert property (p_addr) else $error("start address wrong");
   property p_hw_int;
      $past(I_HW_INT_EN) |-> O_INT_VALID && O_INT_NUM == $past(I_INT_NUM, 3);
   endproperty
   a_hw_int: assert property (p_hw_int) else $error("hw interrupt wrong");
   property p_hw_off; !I_HW_INT_EN && !I_SW_INT_VALID |=> !O_INT_VALID; endproperty
   a_hw_off: assert property (p_hw_off) else $error("pins not ignored");
   property p_sw_int;
      !I_HW_INT_EN && I_SW_INT_VALID |=> O_INT_VALID && O_INT_NUM == $past(I_SW_INT_NUM);
   endproperty
   a_sw_int: assert property (p_sw_int) else $error("sw interrupt wrong");
   property p_sticky; O_REF_SEL_EXT |=> O_REF_SEL_EXT; endproperty
   a_sticky: assert property (p_sticky) else $error("reference dropped");
endmodule

bind pxi_top pxi_chk pxi_chk_i (
   .I_CLK          (I_CLK),
   .I_ARST_N       (I_ARST_N),
   .I_START_N      (I_START_N),
   .I_PC_RESET_N   (I_PC_RESET_N),
   .I_INT_NUM      (I_INT_NUM),
   .I_HW_INT_EN    (I_HW_INT_EN),
   .I_SW_START     (I_SW_START),
   .I_SW_INT_VALID (I_SW_INT_VALID),
   .I_SW_INT_NUM   (I_SW_INT_NUM),
   .O_START        (O_START),
   .O_START_ADDR   (O_START_ADDR),
   .O_PC_CLEAR     (O_PC_CLEAR),
   .O_INT_VALID    (O_INT_VALID),
   .O_INT_NUM      (O_INT_NUM),
   .O_REF_SEL_EXT  (O_REF_SEL_EXT)
);

// *** verif/pxi_lab.sv ***
// Lab equipment on the pins; interrupt lines are weakly pulled high
module pxi_lab (
   input  wire logic       i_ref_on,
   input  wire logic       i_int_drv,
   input  wire logic [7:0] i_int_val,
   output logic [7:0]      o_int_num,
   output logic            o_ref_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   // An unplugged cable leaves the pull-ups in charge
   assign o_int_num = i_int_drv ? i_int_val : 8'hFF;
   // 10 MHz square wave, stands low while unplugged
   initial begin
      o_ref_clk = 1'b0;
      forever #50 o_ref_clk = i_ref_on ? !o_ref_clk : 1'b0;
   end
endmodule

// *** verif/tb_pxi_top.sv ***
module tb_pxi_top;
   timeunit 1ns;
   timeprecision 100ps;
   import pxi_pkg::*;
   logic       clk = 1'b0, arst_n = 1'b0, st_n = 1'b1, pc_n = 1'b1, hw_en = 1'b0;
   logic       sw_st = 1'b0, sw_rs = 1'b0, sw_v = 1'b0, ref_on = 1'b0, drv = 1'b0;
   logic [7:0] val = 8'h00, sw_num = 8'h00, pins, addr, inum;
   logic       rclk, start, clr, iv, ext, det;
   int         errors = 0, n_checks = 0;
   pxi_lab pxi_lab_i (.i_ref_on(ref_on), .i_int_drv(drv), .i_int_val(val),
      .o_int_num(pins), .o_ref_clk(rclk));
   pxi_top pxi_top_i (.I_CLK(clk), .I_ARST_N(arst_n), .I_START_N(st_n),
      .I_PC_RESET_N(pc_n), .I_INT_NUM(pins), .I_REF_CLK(rclk), .I_HW_INT_EN(hw_en),
      .I_SW_START(sw_st), .I_SW_RESET(sw_rs), .I_SW_INT_VALID(sw_v), .I_SW_INT_NUM(sw_num),
      .O_START(start), .O_START_ADDR(addr), .O_PC_CLEAR(clr), .O_INT_VALID(iv),
      .O_INT_NUM(inum), .O_REF_SEL_EXT(ext), .O_REF_DETECTING(det));
   // 40 MHz core clock
   always #12.5 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Widens a one-bit flag for the common compare
   function automatic logic [7:0] b8(input logic b);
      return {7'h00, b};
   endfunction
   // Inputs move just after the edge so no race with sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Held trigger keeps starting from the pin address
   task automatic t_pin;
      hw_en = 1'b1;
      drv = 1'b1;
      val = 8'h19;
      st_n = 1'b0;
      step(3);
      repeat (4) begin
         chk(b8(start), 8'h01);
         chk(addr, 8'h19);
         chk(inum, 8'h19);
         chk(b8(iv), 8'h01);
         step(1);
      end
      drv = 1'b0;
      step(3);
      chk(addr, 8'hFF);
      chk(inum, 8'hFF);
      st_n = 1'b1;
      step(3);
      chk(b8(start), 8'h00);
   endtask
   // Commands from the host, pins must be ignored
   task automatic t_sw;
      hw_en = 1'b0;
      drv = 1'b1;
      val = 8'h5A;
      sw_num = 8'h19;
      sw_st = 1'b1;
      sw_v = 1'b1;
      sw_rs = 1'b1;
      step(1);
      chk(b8(start), 8'h01);
      chk(addr, 8'h19);
      chk(inum, 8'h19);
      chk(b8(clr), 8'h01);
      sw_st = 1'b0;
      sw_v = 1'b0;
      sw_rs = 1'b0;
      step(1);
      chk(b8(iv), 8'h00);
      chk(b8(start), 8'h00);
   endtask
   // Reset pin passes two sync stages before acting
   task automatic t_pc;
      pc_n = 1'b0;
      step(2);
      chk(b8(clr), 8'h00);
      step(1);
      chk(b8(clr), 8'h01);
      pc_n = 1'b1;
   endtask
   // A lone reference edge starts detection, then times out
   task automatic t_glitch;
      logic seen;
      seen = 1'b0;
      ref_on = 1'b1;
      step(3);
      ref_on = 1'b0;
      repeat (12) begin
         step(1);
         if (det === 1'b1) seen = 1'b1;
      end
      chk(b8(seen), 8'h01);
      step(4);
      chk(b8(det), 8'h00);
      chk(b8(ext), 8'h00);
   endtask
   // Reference stays chosen after unplugging until power reset
   task automatic t_ref;
      ref_on = 1'b1;
      for (int i = 0; i < 400 && ext !== 1'b1; i++) step(1);
      chk(b8(ext), 8'h01);
      chk(b8(det), 8'h00);
      ref_on = 1'b0;
      step(40);
      chk(b8(ext), 8'h01);
      arst_n = 1'b0;
      step(2);
      arst_n = 1'b1;
      chk(b8(ext), 8'h00);
      step(2);
      chk(b8(ext), 8'h00);
      chk(b8(start), 8'h00);
   endtask
   // Main sequence
   initial begin
      step(20);
      arst_n = 1'b1;
      step(2);
      t_pin;
      t_sw;
      t_pc;
      t_glitch;
      t_ref;
      summarize;
   end
   // Watchdog at about five times the expected run of some 170 cycles
   initial begin
      #20000;
      errors++;
      summarize;
   end
endmodule
